// file: include/sse_defines.svh
// constants for the shift, subtract and store execution block
`ifndef SSE_DEFINES_SVH
`define SSE_DEFINES_SVH

// -----------------------------------------------------------------------------
// opcode and function codes
// -----------------------------------------------------------------------------
`define SSE_OP_REG_FORMAT   6'h00
`define SSE_OP_STORE_WORD   6'h2B
`define SSE_OP_STORE_UPPER  6'h2A
`define SSE_OP_STORE_LOWER  6'h2E
`define SSE_FN_SHR_IMM      6'h02
`define SSE_FN_SHR_VAR      6'h06
`define SSE_FN_SUB_TRAP     6'h22
`define SSE_FN_SUB_WRAP     6'h23

// -----------------------------------------------------------------------------
// instruction field positions
// -----------------------------------------------------------------------------
`define SSE_OPC_HI          31
`define SSE_OPC_LO          26
`define SSE_SRCA_HI         25
`define SSE_SRCA_LO         21
`define SSE_SRCB_HI         20
`define SSE_SRCB_LO         16
`define SSE_DST_HI          15
`define SSE_DST_LO          11
`define SSE_SHAMT_HI        10
`define SSE_SHAMT_LO        6
`define SSE_FN_HI           5
`define SSE_FN_LO           0
`define SSE_OFFS_HI         15
`define SSE_OFFS_LO         0

// -----------------------------------------------------------------------------
// store size codes: bytes minus one
// -----------------------------------------------------------------------------
`define SSE_SIZE_WORD       2'h3

`endif

// file: include/sse_pkg.sv
// types shared by the shift, subtract and store execution block
package sse_pkg;

	typedef enum logic [2:0]
	{
		SSE_EXC_NONE     = 3'h0,
		SSE_EXC_OVERFLOW = 3'h1,
		SSE_EXC_ADDR     = 3'h3
	} sse_exc_t;

	typedef struct packed
	{
		logic        wr_en;
		logic [4:0]  wr_idx;
		logic [31:0] wr_data;
		logic        st_en;
		logic [31:0] st_virt_addr;
		logic [1:0]  st_pa_low;
		logic        st_pa_low_force;
		logic [31:0] st_data;
		logic [1:0]  st_size;
		logic [3:0]  st_byte_en;
		logic        exc_valid;
		sse_exc_t    exc_code;
		logic        busy;
	} sse_state_t;

endpackage

// file: hw/sse_exec.sv
// execution unit for logical right shift, subtract and word stores
//
// How it works
// - immediate right shift moves the second source right by shift field, zero fill.
// - function 000110 shifts right by only low five bits of first source.
// - trapping subtract flags overflow when bits 32 and 31 of 33-bit result differ.
// - on overflow no register write, integer overflow exception raised.
// - without overflow the 32-bit difference is written to destination.
// - wrapping subtract writes modulo difference and never traps.
// - full word store address is base plus sign-extended offset, writes whole register.
// - full word store with low address bits nonzero raises address error, no write.
// - full word store reports only translation faults and address error.
// - upper part store writes top one to four bytes toward word boundary.
// - lower part store writes bottom one to four bytes of the register.
// - bytes written depend on low address bits and processor byte order.
// - upper store index is address xor order; data is upper bytes, size is index.
// - physical low bits xor order flip; forced zero when memory order is little.
// - upper part store never faults for misalignment.
// - lower and upper part stores together cover all four bytes of the word.
// - lower store shifts register up by eight times index; size is word minus index.
`timescale 1ns/1ps
`default_nettype none
`include "sse_defines.svh"

module sse_exec
	import sse_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic        i_issue_valid,
	input  wire logic [31:0] i_instr,
	input  wire logic [31:0] i_src_a,
	input  wire logic [31:0] i_src_b,
	input  wire logic        i_cpu_big_order,
	input  wire logic        i_user_order_flip,
	input  wire logic        i_mem_big_order,
	input  wire logic        i_mem_ready,
	output logic             o_issue_ready,
	output logic             o_wr_en,
	output logic [4:0]       o_wr_idx,
	output logic [31:0]      o_wr_data,
	output logic             o_st_valid,
	output logic [31:0]      o_st_virt_addr,
	output logic [1:0]       o_st_pa_low,
	output logic             o_st_pa_low_force,
	output logic [31:0]      o_st_data,
	output logic [1:0]       o_st_size,
	output logic [3:0]       o_st_byte_en,
	output logic             o_exc_valid,
	output sse_exc_t         o_exc_code
);

	// -------------------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------------------
	// lane mask of size+1 bytes starting at memory lane base, upward
	function automatic logic [3:0] lane_mask(input logic [1:0] base, input logic [1:0] size);
		logic [3:0] run;
		run = 4'h0;
		unique case (size)
			2'h0: run = 4'h1;
			2'h1: run = 4'h3;
			2'h2: run = 4'h7;
			2'h3: run = 4'hF;
		endcase
		lane_mask = 4'((run << base) & 4'hF);
	endfunction

	sse_state_t q;
	sse_state_t next_q;

	logic [5:0]  opc;
	logic [5:0]  fn;
	logic [31:0] virt_addr;
	logic [32:0] diff_wide;
	logic [1:0]  byte_idx;
	logic        overflow;
	logic        accept;

	assign opc       = i_instr[`SSE_OPC_HI:`SSE_OPC_LO];
	assign fn        = i_instr[`SSE_FN_HI:`SSE_FN_LO];
	assign virt_addr     = i_src_a + {{16{i_instr[`SSE_OFFS_HI]}}, i_instr[`SSE_OFFS_HI:`SSE_OFFS_LO]};
	assign diff_wide = {i_src_a[31], i_src_a} - {i_src_b[31], i_src_b};
	assign overflow  = diff_wide[32] ^ diff_wide[31];
	assign byte_idx  = virt_addr[1:0] ^ {2{i_cpu_big_order}};
	// a pending store holds the unit until memory takes it
	assign accept        = i_issue_valid && !(q.busy && !i_mem_ready);
	assign o_issue_ready = !(q.busy && !i_mem_ready);

	// -------------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------------
	always_comb
	begin
		next_q           = q;
		next_q.wr_en     = 1'b0;
		next_q.exc_valid = 1'b0;
		next_q.exc_code  = SSE_EXC_NONE;
		if (q.busy && i_mem_ready)
		begin
			next_q.busy  = 1'b0;
			next_q.st_en = 1'b0;
		end
		if (accept)
		begin
			next_q.wr_idx = i_instr[`SSE_DST_HI:`SSE_DST_LO];
			if (opc == `SSE_OP_REG_FORMAT)
			begin
				unique case (fn)
					`SSE_FN_SHR_IMM:
					begin
						next_q.wr_en   = 1'b1;
						next_q.wr_data = i_src_b >> i_instr[`SSE_SHAMT_HI:`SSE_SHAMT_LO];
					end
					`SSE_FN_SHR_VAR:
					begin
						next_q.wr_en   = 1'b1;
						next_q.wr_data = i_src_b >> i_src_a[4:0];
					end
					`SSE_FN_SUB_TRAP:
					begin
						// destination left alone on overflow
						next_q.wr_en     = !overflow;
						next_q.wr_data   = diff_wide[31:0];
						next_q.exc_valid = overflow;
						next_q.exc_code  = overflow ? SSE_EXC_OVERFLOW : SSE_EXC_NONE;
					end
					`SSE_FN_SUB_WRAP:
					begin
						next_q.wr_en   = 1'b1;
						next_q.wr_data = i_src_a - i_src_b;
					end
					default:
					begin
						next_q.wr_en = 1'b0;
					end
				endcase
			end
			else if (opc == `SSE_OP_STORE_WORD)
			begin
				next_q.st_virt_addr        = virt_addr;
				next_q.st_pa_low       = 2'h0;
				next_q.st_pa_low_force = 1'b0;
				next_q.st_data         = i_src_b;
				next_q.st_size         = `SSE_SIZE_WORD;
				next_q.st_byte_en      = 4'hF;
				if (virt_addr[1:0] != 2'h0)
				begin
					// translation faults come from the memory side; only this is ours
					next_q.exc_valid = 1'b1;
					next_q.exc_code  = SSE_EXC_ADDR;
				end
				else
				begin
					next_q.st_en = 1'b1;
					next_q.busy  = 1'b1;
				end
			end
			else if (opc == `SSE_OP_STORE_UPPER || opc == `SSE_OP_STORE_LOWER)
			begin
				// no alignment check for partial stores
				next_q.st_en           = 1'b1;
				next_q.busy            = 1'b1;
				next_q.st_virt_addr        = virt_addr;
				next_q.st_pa_low       = {2{i_user_order_flip}};
				next_q.st_pa_low_force = !i_mem_big_order;
				if (opc == `SSE_OP_STORE_UPPER)
				begin
					next_q.st_data    = i_src_b >> (5'd24 - {byte_idx, 3'h0});
					next_q.st_size    = byte_idx;
					// data sits in the low lanes of the aligned word
					next_q.st_byte_en = lane_mask(2'h0, byte_idx);
				end
				else
				begin
					next_q.st_data    = i_src_b << {byte_idx, 3'h0};
					next_q.st_size    = 2'(`SSE_SIZE_WORD - byte_idx);
					next_q.st_byte_en = lane_mask(byte_idx, 2'(`SSE_SIZE_WORD - byte_idx));
				end
			end
		end
		if (i_rst)
		begin
			next_q = '0;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		q <= next_q;
	end

	// -------------------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------------------
	assign o_wr_en           = q.wr_en;
	assign o_wr_idx          = q.wr_idx;
	assign o_wr_data         = q.wr_data;
	assign o_st_valid        = q.st_en;
	assign o_st_virt_addr        = q.st_virt_addr;
	assign o_st_pa_low       = q.st_pa_low;
	assign o_st_pa_low_force = q.st_pa_low_force;
	assign o_st_data         = q.st_data;
	assign o_st_size         = q.st_size;
	assign o_st_byte_en      = q.st_byte_en;
	assign o_exc_valid       = q.exc_valid;
	assign o_exc_code        = q.exc_code;

endmodule

`default_nettype wire

// file: tb/sse_exec_checker.sv
// assertion checker for the shift, subtract and store unit
`timescale 1ns/1ps
`default_nettype none
module sse_exec_checker
	import sse_pkg::*;
(
	input wire logic        i_core_clk,
	input wire logic        i_rst,
	input wire logic        i_issue_valid,
	input wire logic [31:0] i_instr,
	input wire logic [31:0] i_src_a,
	input wire logic [31:0] i_src_b,
	input wire logic        o_issue_ready,
	input wire logic        o_wr_en,
	input wire logic [31:0] o_wr_data,
	input wire logic        o_st_valid,
	input wire logic [31:0] o_st_virt_addr,
	input wire logic [31:0] o_st_data,
	input wire logic [3:0]  o_st_byte_en,
	input wire logic        o_exc_valid,
	input wire sse_exc_t    o_exc_code
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);
	wire        ac = i_issue_valid && o_issue_ready;
	wire        rf = ac && i_instr[31:26] == 6'h00;
	wire        sw = ac && i_instr[31:26] == 6'h2B;
	wire [5:0]  fn = i_instr[5:0];
	wire [32:0] df = {i_src_a[31], i_src_a} - {i_src_b[31], i_src_b};
	wire        ov = df[32] != df[31];
	wire [31:0] ea = i_src_a + {{16{i_instr[15]}}, i_instr[15:0]};
	property p_shr_imm; rf && fn == 6'h02 |=> o_wr_en && o_wr_data == $past(i_src_b) >> $past(i_instr[10:6]); endproperty
	a_shr_imm: assert property (p_shr_imm) else $error("shift imm wrong");
	property p_shr_var; rf && fn == 6'h06 |=> o_wr_en && o_wr_data == $past(i_src_b) >> $past(i_src_a[4:0]); endproperty
	a_shr_var: assert property (p_shr_var) else $error("shift var wrong");
	property p_ovf; rf && fn == 6'h22 && ov |=> o_exc_valid && o_exc_code == SSE_EXC_OVERFLOW && !o_wr_en; endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not trapped");
	property p_sub; rf && fn == 6'h22 && !ov |=> o_wr_en && !o_exc_valid && o_wr_data == $past(df[31:0]); endproperty
	a_sub: assert property (p_sub) else $error("difference wrong");
	property p_wrap; rf && fn == 6'h23 |=> o_wr_en && !o_exc_valid && o_wr_data == $past(df[31:0]); endproperty
	a_wrap: assert property (p_wrap) else $error("wrap wrong");
	property p_mis; sw && ea[1:0] != 2'h0 |=> o_exc_valid && o_exc_code == SSE_EXC_ADDR && !o_st_valid; endproperty
	a_mis: assert property (p_mis) else $error("misaligned store");
	property p_full; sw && ea[1:0] == 2'h0 |=> o_st_valid && o_st_virt_addr == $past(ea) && o_st_data == $past(i_src_b) && o_st_byte_en == 4'hF; endproperty
	a_full: assert property (p_full) else $error("full store wrong");
	property p_upper; ac && i_instr[31:26] == 6'h2A |=> o_st_valid && !o_exc_valid; endproperty
	a_upper: assert property (p_upper) else $error("upper store faulted");
endmodule
bind sse_exec sse_exec_checker u_chk (.i_core_clk, .i_rst, .i_issue_valid, .i_instr, .i_src_a,
	.i_src_b, .o_issue_ready, .o_wr_en, .o_wr_data, .o_st_valid, .o_st_virt_addr, .o_st_data,
	.o_st_byte_en, .o_exc_valid, .o_exc_code);
`default_nettype wire

// file: tb/sse_mem_model.sv
// data memory side model: takes stores, optionally slowly
`timescale 1ns/1ps
`default_nettype none
module sse_mem_model
(
	input  wire logic       i_core_clk,
	input  wire logic       i_slow,
	input  wire logic       i_clr,
	input  wire logic       i_st_valid,
	input  wire logic [3:0] i_st_byte_en,
	output logic            o_mem_ready,
	output logic [3:0]      o_lanes
);
	logic [1:0] cnt = 2'h0;
	initial o_mem_ready = 1'b1;
	initial o_lanes = 4'h0;
	always @(negedge i_core_clk)
	begin
		cnt = (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
		o_mem_ready <= !i_slow || cnt == 2'h0;
	end
	// lanes gathered so a pair of partial stores is judged whole
	always @(posedge i_core_clk)
		if (i_clr)
			o_lanes <= 4'h0;
		else if (i_st_valid && o_mem_ready)
			o_lanes <= o_lanes | i_st_byte_en;
endmodule
`default_nettype wire

// file: tb/tb_shift_sub_store_exec.sv
// self-checking bench for the shift, subtract and store unit
`timescale 1ns/1ps
`default_nettype none
module tb_shift_sub_store_exec;
	import sse_pkg::*;
	logic        clk = 0, rst = 1, vld = 0, cb = 0, fl = 0, mb = 0, slow = 0, clr = 0;
	logic [31:0] ins = 32'h0, a = 32'h0, b = 32'h0, wd, sv, sd;
	logic        rdy, mr, we, st, frc, ev;
	logic [1:0]  pl, sz, x;
	logic [3:0]  be, ln;
	logic [4:0]  wi;
	sse_exc_t    ec;
	int          bad_count = 0, cmp_count = 0;
	always #25 clk = !clk;
	sse_exec dut (.i_core_clk(clk), .i_rst(rst), .i_issue_valid(vld), .i_instr(ins),
		.i_src_a(a), .i_src_b(b), .i_cpu_big_order(cb), .i_user_order_flip(fl),
		.i_mem_big_order(mb), .i_mem_ready(mr), .o_issue_ready(rdy), .o_wr_en(we),
		.o_wr_idx(wi), .o_wr_data(wd), .o_st_valid(st), .o_st_virt_addr(sv), .o_st_pa_low(pl),
		.o_st_pa_low_force(frc), .o_st_data(sd), .o_st_size(sz), .o_st_byte_en(be),
		.o_exc_valid(ev), .o_exc_code(ec));
	sse_mem_model mem (.i_core_clk(clk), .i_slow(slow), .i_clr(clr), .i_st_valid(st),
		.i_st_byte_en(be), .o_mem_ready(mr), .o_lanes(ln));
	task chk(input string n, input logic [39:0] s, input logic [39:0] e);
		cmp_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// held until taken; returns one half cycle after the taking edge
	task issue(input logic [31:0] i, input logic [31:0] p, input logic [31:0] q);
		@(negedge clk);
		{ins, a, b, vld} = {i, p, q, 1'b1};
		// ready follows the memory side, which moves on this same edge: look once it settled
		#1;
		for (int n = 0; n < 50 && rdy !== 1'b1; n++)
		begin
			@(negedge clk);
			#1;
		end
		chk("issue ready", rdy, 1'b1);
		@(negedge clk);
		vld = 0;
	endtask
	task t_arith;
		issue({16'h0, 5'h05, 5'h1F, 6'h02}, 32'h0, 32'h8000_0000);
		chk("shift imm", {wi, we, wd}, {5'h05, 1'b1, 32'h1});
		issue({26'h0, 6'h06}, 32'hFFFF_FFE4, 32'hF000_0000);
		chk("shift var", wd, 32'h0F00_0000);
		issue({26'h0, 6'h22}, 32'h8000_0000, 32'h1);
		chk("ovf", {ev, we, ec}, {2'h2, SSE_EXC_OVERFLOW});
		issue({26'h0, 6'h22}, 32'h8000_0000, 32'hFFFF_FFFF);
		chk("diff", {we, ev, wd}, {2'h2, 32'h8000_0001});
		issue({26'h0, 6'h23}, 32'h8000_0000, 32'h1);
		chk("wrap", {we, ev, wd}, {2'h2, 32'h7FFF_FFFF});
	endtask
	task t_full;
		issue({6'h2B, 10'h0, 16'hFFFC}, 32'h1000, 32'hA5C3_0001);
		chk("full", {st, be, sz, sv}, {1'b1, 4'hF, 2'h3, 32'h0FFC});
		issue({6'h2B, 10'h0, 16'h0002}, 32'h1000, 32'h5);
		chk("misalign", {st, ev, ec}, {2'h1, SSE_EXC_ADDR});
	endtask
	task t_part;
		for (int o = 0; o < 2; o++)
			for (int k = 0; k < 4; k++)
			begin
				{cb, fl, mb, slow, clr} = {o[0], !o[0], o[0], o[0], 1'b1};
				x = k[1:0] ^ {2{o[0]}};
				issue({6'h2A, 10'h0, 16'(k + 4)}, 32'h2000, 32'h1122_3344);
				clr = 0;
				chk("upper", {sz, be, sd}, {x, 4'hF >> (2'h3 - x), 32'h1122_3344 >> (24 - 8 * x)});
				chk("pa", {pl, frc, sv}, {{2{!o[0]}}, !o[0], 32'h2000 + 32'(k + 4)});
				x = (k[1:0] + 2'h1 + {o[0], 1'b0}) ^ {2{o[0]}};
				issue({6'h2E, 10'h0, 16'(k + 1 + 2 * o)}, 32'h2000, 32'h1122_3344);
				chk("lower", {sz, be, sd}, {2'h3 - x, 4'hF << x, 32'h1122_3344 << (8 * x)});
				for (int n = 0; n < 20 && st === 1'b1; n++)
					@(negedge clk);
				chk("pair", ln, 4'hF);
			end
	endtask
	initial
	begin
		repeat (12) @(negedge clk);
		rst = 0;
		t_arith;
		t_full;
		t_part;
		give_verdict;
	end
	initial
	begin
		#200000;
		bad_count++;
		give_verdict;
	end
endmodule
`default_nettype wire
